// File: fps_consts.svh
`ifndef FPS_CONSTS_SVH
`define FPS_CONSTS_SVH

// ----------------------------------------------------------------
// Result byte bit positions
// ----------------------------------------------------------------
`define FPS_RES_SF 0
`define FPS_RES_FQ 1
`define FPS_RES_BR 2
`define FPS_RES_WA 1
`define FPS_RES_WD 2
`define FPS_RES_EB 3
`define FPS_RES_FK 4
`define FPS_RES_EE 5
`define FPS_RES_MD 6

// ----------------------------------------------------------------
// Values and geometry
// ----------------------------------------------------------------
`define FPS_RES_RESET 8'h00
`define FPS_KEY_OK 8'h5A
`define FPS_MAT_BOOT 8'hAA
`define FPS_PAGE_LSB 7
`define FPS_PAGE_LAST 7'h7F
`define FPS_CNT_ZERO 7'h00
`define FPS_CNT_ONE 7'h01
`define FPS_BLK_HI_ZERO 24'h000000
`define FPS_BLK_MAX 8'h0F
`define FPS_BRANCH_NONE 32'h00000000
`define FPS_DL_SIZE 32'h00000800

`endif

// File: fps_flash_seq.sv
// Notes on behaviour
// - Init sets bit 2 when nonzero branch target hits download area.
// - Init sets bit 1 when frequency lies outside supported range.
// - Init bit 0 flags failure; bits 7 to 3 read zero.
// - Program writes 128 contiguous bytes from aligned destination.
// - Program sets bit 2 when source is in flash or download area.
// - Program sets bit 1 for destination outside flash or unaligned.
// - Program sets bit 6 and refuses while protection flag is set.
// - Program sets bit 5 for unerased page or altered registers.
// - Mat select AA blocks program, flags bit 5, nothing changes.
// - Program sets bit 4 unless key register holds 5A.
// - Program bit 0 flags abnormal termination.
// - Erase block must be 0 to 15 with upper bits zero.
// - Erase sets bit 3 for block number out of range.
// - Erase sets bit 5 on failure, altered registers, or boot area.
// - Erase sets bit 6 and refuses while protection flag is set.
// - Erase sets bit 4 unless key register holds 5A.
// - Erase bit 0 flags failure; bits 7, 2 and 1 read zero.
`include "fps_consts.svh"
`default_nettype none

module fps_flash_seq #(
  parameter logic [31:0] FLASH_BASE = 32'h00000000,
  parameter logic [31:0] FLASH_SIZE = 32'h00080000,
  parameter logic [31:0] DL_BASE = 32'h0000F000,
  parameter logic [15:0] FREQ_MIN = 16'h03E8,
  parameter logic [15:0] FREQ_MAX = 16'h09C4,
  parameter int PAGE_W = 12,
  parameter int BLK_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire fps_pkg::fps_req_t req,
  input wire logic [7:0] key_register,
  input wire logic [7:0] mat_select_register,
  input wire logic error_protection_flag,
  input wire logic regs_altered,
  output logic busy,
  output logic done,
  output logic [7:0] pass_fail_result,
  output logic wr_strobe,
  output logic [31:0] wr_dest_addr,
  output logic [31:0] rd_src_addr,
  output logic erase_strobe,
  output logic [BLK_W-1:0] erase_block
);

  fps_pkg::fps_state_t state_ff;
  fps_pkg::fps_state_t nxt_state;
  fps_pkg::fps_req_t req_ff;
  fps_pkg::fps_req_t nxt_req;
  logic [7:0] res_ff;
  logic [7:0] nxt_res;
  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic busy_ff;
  logic nxt_busy;
  logic done_ff;
  logic nxt_done;
  logic wr_stb_ff;
  logic nxt_wr_stb;
  logic [31:0] wr_addr_ff;
  logic [31:0] nxt_wr_addr;
  logic [31:0] rd_addr_ff;
  logic [31:0] nxt_rd_addr;
  logic ers_stb_ff;
  logic nxt_ers_stb;
  logic [BLK_W-1:0] ers_blk_ff;
  logic [BLK_W-1:0] nxt_ers_blk;

  logic branch_in_dl;
  logic src_in_flash;
  logic src_in_dl;
  logic dest_in_flash;
  logic page_written;
  logic mark_page;
  logic clear_block;
  logic [31:0] dest_off;
  logic [7:0] chk_res;
  logic key_bad;
  logic boot_sel;
  logic blk_bad;

  // ----------------------------------------------------------------
  // Address window checks
  // ----------------------------------------------------------------
  fps_range_check u_branch_dl (
    .addr(req_ff.branch),
    .base(DL_BASE),
    .size(`FPS_DL_SIZE),
    .hit(branch_in_dl)
  );

  fps_range_check u_src_flash (
    .addr(req_ff.src),
    .base(FLASH_BASE),
    .size(FLASH_SIZE),
    .hit(src_in_flash)
  );

  fps_range_check u_src_dl (
    .addr(req_ff.src),
    .base(DL_BASE),
    .size(`FPS_DL_SIZE),
    .hit(src_in_dl)
  );

  fps_range_check u_dest_flash (
    .addr(req_ff.dest),
    .base(FLASH_BASE),
    .size(FLASH_SIZE),
    .hit(dest_in_flash)
  );

  // ----------------------------------------------------------------
  // Page written tracking
  // ----------------------------------------------------------------
  fps_page_state #(
    .PAGE_W(PAGE_W),
    .BLK_W(BLK_W)
  ) u_pages (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .page_idx(dest_off[`FPS_PAGE_LSB +: PAGE_W]),
    .mark_page(mark_page),
    .clear_block(clear_block),
    .block_idx(req_ff.block[BLK_W-1:0]),
    .page_written(page_written)
  );

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  always_comb begin
    dest_off = req_ff.dest - FLASH_BASE;
    key_bad = (key_register != `FPS_KEY_OK);
    boot_sel = (mat_select_register == `FPS_MAT_BOOT);
    blk_bad = (req_ff.block[31:8] != `FPS_BLK_HI_ZERO) ||
      (req_ff.block[7:0] > `FPS_BLK_MAX);
    chk_res = `FPS_RES_RESET;
    case (req_ff.op)
      fps_pkg::FPS_OP_INIT: begin
        chk_res[`FPS_RES_BR] = branch_in_dl &&
          (req_ff.branch != `FPS_BRANCH_NONE);
        chk_res[`FPS_RES_FQ] = (req_ff.freq < FREQ_MIN) ||
          (req_ff.freq > FREQ_MAX);
      end
      fps_pkg::FPS_OP_PROG: begin
        chk_res[`FPS_RES_MD] = error_protection_flag;
        chk_res[`FPS_RES_FK] = key_bad;
        chk_res[`FPS_RES_WD] = src_in_flash || src_in_dl;
        chk_res[`FPS_RES_WA] = !dest_in_flash ||
          (req_ff.dest[`FPS_PAGE_LSB-1:0] != `FPS_CNT_ZERO);
        chk_res[`FPS_RES_EE] = boot_sel ||
          (dest_in_flash && page_written);
      end
      fps_pkg::FPS_OP_ERASE: begin
        chk_res[`FPS_RES_MD] = error_protection_flag;
        chk_res[`FPS_RES_FK] = key_bad;
        chk_res[`FPS_RES_EB] = blk_bad;
        chk_res[`FPS_RES_EE] = boot_sel;
      end
      default: begin
        chk_res[`FPS_RES_EE] = 1'b1;
      end
    endcase
    chk_res[`FPS_RES_SF] = |chk_res[7:1];
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_res = res_ff;
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_wr_stb = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_rd_addr = rd_addr_ff;
    nxt_ers_stb = 1'b0;
    nxt_ers_blk = ers_blk_ff;
    mark_page = 1'b0;
    clear_block = 1'b0;
    case (state_ff)
      fps_pkg::FPS_ST_IDLE: begin
        if (start) begin
          nxt_req = req;
          nxt_busy = 1'b1;
          nxt_state = fps_pkg::FPS_ST_CHECK;
        end
      end
      fps_pkg::FPS_ST_CHECK: begin
        nxt_res = chk_res;
        nxt_cnt = `FPS_CNT_ZERO;
        if (chk_res[`FPS_RES_SF] || req_ff.op == fps_pkg::FPS_OP_INIT) begin
          nxt_state = fps_pkg::FPS_ST_DONE;
        end else if (req_ff.op == fps_pkg::FPS_OP_PROG) begin
          mark_page = 1'b1;
          nxt_wr_stb = 1'b1;
          nxt_wr_addr = req_ff.dest;
          nxt_rd_addr = req_ff.src;
          nxt_state = fps_pkg::FPS_ST_WORK;
        end else begin
          clear_block = 1'b1;
          nxt_ers_stb = 1'b1;
          nxt_ers_blk = req_ff.block[BLK_W-1:0];
          nxt_state = fps_pkg::FPS_ST_WORK;
        end
      end
      fps_pkg::FPS_ST_WORK: begin
        if (regs_altered) begin
          nxt_res[`FPS_RES_EE] = 1'b1;
          nxt_res[`FPS_RES_SF] = 1'b1;
        end
        if (req_ff.op == fps_pkg::FPS_OP_PROG &&
            cnt_ff != `FPS_PAGE_LAST) begin
          nxt_cnt = cnt_ff + `FPS_CNT_ONE;
          nxt_wr_stb = 1'b1;
          nxt_wr_addr = req_ff.dest + 32'(nxt_cnt);
          nxt_rd_addr = req_ff.src + 32'(nxt_cnt);
        end else begin
          nxt_state = fps_pkg::FPS_ST_DONE;
        end
      end
      fps_pkg::FPS_ST_DONE: begin
        nxt_done = 1'b1;
        nxt_busy = 1'b0;
        nxt_state = fps_pkg::FPS_ST_IDLE;
      end
      default: begin
        nxt_busy = 1'b0;
        nxt_state = fps_pkg::FPS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= fps_pkg::FPS_ST_IDLE;
      req_ff <= '0;
      res_ff <= `FPS_RES_RESET;
      cnt_ff <= `FPS_CNT_ZERO;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      wr_stb_ff <= 1'b0;
      wr_addr_ff <= '0;
      rd_addr_ff <= '0;
      ers_stb_ff <= 1'b0;
      ers_blk_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      res_ff <= nxt_res;
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      wr_stb_ff <= nxt_wr_stb;
      wr_addr_ff <= nxt_wr_addr;
      rd_addr_ff <= nxt_rd_addr;
      ers_stb_ff <= nxt_ers_stb;
      ers_blk_ff <= nxt_ers_blk;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    busy = busy_ff;
    done = done_ff;
    pass_fail_result = res_ff;
    wr_strobe = wr_stb_ff;
    wr_dest_addr = wr_addr_ff;
    rd_src_addr = rd_addr_ff;
    erase_strobe = ers_stb_ff;
    erase_block = ers_blk_ff;
  end

endmodule

`default_nettype wire

// File: fps_flash_seq_props.sv
`default_nettype none

module fps_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire fps_pkg::fps_req_t req,
  input wire logic [7:0] key_register,
  input wire logic [7:0] mat_select_register,
  input wire logic error_protection_flag,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] pass_fail_result,
  input wire logic wr_strobe,
  input wire logic [31:0] wr_dest_addr,
  input wire logic [31:0] rd_src_addr,
  input wire logic erase_strobe
);
  // ----
  // Operation kind of the request in flight.
  // ----
  logic [2:0] op_ff;
  logic [2:0] nxt_op;
  always_comb nxt_op = (start && !busy) ? req.op : op_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) op_ff <= 3'h0;
    else op_ff <= nxt_op;
  end
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_done_pulse: assert property (
    done |=> !done && !busy) else $error("done too long");
  a_sf_summary: assert property (
    done |-> pass_fail_result[0] == |pass_fail_result[7:1])
    else $error("summary bit wrong");
  a_init_zero: assert property (
    done && op_ff == 3'h1 |-> pass_fail_result[7:3] == 5'h00)
    else $error("init reserved bits set");
  a_erase_zero: assert property (
    done && op_ff == 3'h4 |-> !pass_fail_result[7] &&
    pass_fail_result[2:1] == 2'h0) else $error("erase reserved bits set");
  a_prot_flag: assert property (
    $rose(busy) && op_ff != 3'h1 |-> ##1
    pass_fail_result[6] == $past(error_protection_flag) &&
    !($past(error_protection_flag) && (wr_strobe || erase_strobe)))
    else $error("protection check wrong");
  a_key_check: assert property (
    $rose(busy) && op_ff != 3'h1 |-> ##1
    pass_fail_result[4] == ($past(key_register) != 8'h5A))
    else $error("key check wrong");
  a_boot_refuse: assert property (
    $rose(busy) && op_ff != 3'h1 && mat_select_register == 8'hAA |-> ##1
    pass_fail_result[5] && !wr_strobe && !erase_strobe)
    else $error("boot area not refused");
  a_wr_align: assert property (
    $rose(wr_strobe) |-> wr_dest_addr[6:0] == 7'h00 &&
    pass_fail_result[2:1] == 2'h0) else $error("bad burst start");
  a_wr_step: assert property (
    wr_strobe && $past(wr_strobe) |->
    wr_dest_addr == $past(wr_dest_addr) + 32'h1 &&
    rd_src_addr == $past(rd_src_addr) + 32'h1) else $error("burst gap");
  a_wr_last: assert property (
    $fell(wr_strobe) |-> ($past(wr_dest_addr) & 32'h7F) == 32'h7F ##1 done)
    else $error("burst length wrong");
  a_done_bound: assert property (
    $rose(busy) |-> ##[1:130] done) else $error("no done");
endmodule

bind fps_flash_seq fps_chk u_chk (
  .sys_clk, .rst_n, .start, .req, .key_register, .mat_select_register,
  .error_protection_flag, .busy, .done, .pass_fail_result, .wr_strobe,
  .wr_dest_addr, .rd_src_addr, .erase_strobe
);

`default_nettype wire

// File: fps_flash_seq_tb_top.sv
`default_nettype none

module fps_flash_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Stimulus, model state and design instance.
  // ----
  localparam logic [31:0] FSZ = 32'h00080000;
  localparam logic [31:0] DLB = 32'h0000F000;
  localparam logic [31:0] SRC = 32'h00100000;
  localparam fps_pkg::fps_op_t OPI = fps_pkg::FPS_OP_INIT;
  localparam fps_pkg::fps_op_t OPP = fps_pkg::FPS_OP_PROG;
  localparam fps_pkg::fps_op_t OPE = fps_pkg::FPS_OP_ERASE;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  fps_pkg::fps_req_t req = '0;
  logic [7:0] key_register = 8'h5A;
  logic [7:0] mat_select_register = 8'h00;
  logic error_protection_flag = 1'b0;
  logic regs_altered = 1'b0;
  logic busy;
  logic done;
  logic [7:0] pass_fail_result;
  logic wr_strobe;
  logic [31:0] wr_dest_addr;
  logic [31:0] rd_src_addr;
  logic erase_strobe;
  logic [3:0] erase_block;
  logic [4095:0] pg = '0;
  logic [7:0] kv = 8'h5A;
  logic [7:0] mv = 8'h00;
  logic fv = 1'b0;
  logic av = 1'b0;
  logic [31:0] r;
  logic [31:0] r2;
  logic [31:0] x;
  logic [31:0] y;
  fps_pkg::fps_op_t op;
  int nw = 0;
  int ne = 0;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 32'h83c2;
  fps_flash_seq #(.FLASH_SIZE(FSZ), .DL_BASE(DLB)) uut (
    .sys_clk, .rst_n, .start, .req, .key_register, .mat_select_register,
    .error_protection_flag, .regs_altered, .busy, .done, .pass_fail_result,
    .wr_strobe, .wr_dest_addr, .rd_src_addr, .erase_strobe, .erase_block
  );
  initial forever #25 sys_clk = ~sys_clk;
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_res(input logic [7:0] g, input logic [7:0] e);
    chk_val({24'h0, g}, {24'h0, e});
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic in_dl(input logic [31:0] a);
    return a >= DLB && a < DLB + 32'h800;
  endfunction
  // ----
  // Expected result byte before any late operation error.
  // ----
  function automatic logic [7:0] exp_res();
    logic [7:0] e;
    e = 8'h00;
    if (req.op == OPI) begin
      e[2] = req.branch != 32'h0 && in_dl(req.branch);
      e[1] = req.freq < 16'h03E8 || req.freq > 16'h09C4;
    end else begin
      e[6] = error_protection_flag;
      e[4] = key_register != 8'h5A;
      e[5] = mat_select_register == 8'hAA;
    end
    if (req.op == OPP) begin
      e[2] = req.src < FSZ || in_dl(req.src);
      e[1] = req.dest >= FSZ || req.dest[6:0] != 7'h00;
      e[5] = e[5] || (req.dest < FSZ && pg[req.dest[18:7]]);
    end
    if (req.op == OPE) e[3] = req.block > 32'h0F;
    if (req.op != OPI && req.op != OPP && req.op != OPE) e = 8'h20;
    return e;
  endfunction
  always @(posedge sys_clk) begin
    if (wr_strobe) begin
      chk_val(wr_dest_addr, req.dest + nw);
      chk_val(rd_src_addr, req.src + nw);
      nw++;
    end
    if (erase_strobe) begin
      chk_val({28'h0, erase_block}, req.block);
      ne++;
    end
  end
  task automatic run(input fps_pkg::fps_op_t o, input logic [31:0] a,
                     input logic [31:0] s, input logic [15:0] f);
    logic [7:0] e;
    logic ok;
    nw = 0;
    ne = 0;
    @(posedge sys_clk);
    req <= '{o, f, a, a, s, a};
    key_register <= kv;
    mat_select_register <= mv;
    error_protection_flag <= fv;
    regs_altered <= av;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    @(posedge sys_clk);
    chk_res({7'h0, busy}, 8'h01);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (int k = 0; k < 200 && done !== 1'b1; k++) @(posedge sys_clk);
    chk_res({6'h0, busy, done}, 8'h01);
    e = exp_res();
    ok = e == 8'h00;
    e[5] = e[5] || (ok && av && o != OPI);
    e[0] = |e[7:1];
    chk_res(pass_fail_result, e);
    chk_val(nw, (ok && o == OPP) ? 128 : 0);
    chk_val(ne, (ok && o == OPE) ? 1 : 0);
    if (ok && o == OPP) pg[a[18:7]] = 1'b1;
    if (ok && o == OPE) begin
      for (int k = 0; k < 256; k++) pg[{a[3:0], k[7:0]}] = 1'b0;
    end
  endtask
  initial begin
    #(50 * 40000);
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    run(OPI, 32'h0, 32'h0, 16'h03E7);
    run(OPI, DLB, 32'h0, 16'h03E8);
    run(OPI, DLB + 32'h7FF, 32'h0, 16'h09C4);
    run(OPI, DLB + 32'h800, 32'h0, 16'h09C5);
    $display("init boundaries done");
    for (int b = 0; b < 16; b++) run(OPE, b, 32'h0, 16'h0);
    run(OPE, 32'h10, 32'h0, 16'h0);
    run(OPE, 32'h100, 32'h0, 16'h0);
    $display("erase blocks done");
    for (int i = 0; i < 5; i++) begin
      kv = (i == 1) ? 8'hA5 : 8'h5A;
      mv = (i == 2) ? 8'hAA : 8'h00;
      fv = i == 3;
      av = i == 4;
      run(OPE, 32'h3, 32'h0, 16'h0);
      run(OPP, i * 32'h80, SRC, 16'h0);
    end
    av = 1'b0;
    run(OPP, 32'h0, SRC, 16'h0);
    run(OPP, 32'h40, SRC, 16'h0);
    run(OPP, FSZ, SRC, 16'h0);
    run(OPP, 32'h180, 32'h100, 16'h0);
    run(OPP, 32'h180, DLB + 32'h10, 16'h0);
    run(OPE, 32'h0, 32'h0, 16'h0);
    run(OPP, 32'h0, SRC, 16'h0);
    run(fps_pkg::fps_op_t'(3'h3), 32'h0, 32'h0, 16'h0);
    $display("program checks done");
    for (int i = 0; i < 30; i++) begin
      r = $random(seed);
      r2 = $random(seed);
      op = r[5:4] == 2'h0 ? OPI : (r[5:4] == 2'h1 ? OPP : OPE);
      x = {13'h0, r2[18:7], 7'h00};
      if (op == OPP && pg[x[18:7]]) r[3:0] = 4'h0;
      if (op == OPE) x = {28'h0, r2[18:15]};
      if (op == OPE && r[3:0] == 4'h5) x = {24'h0, r2[7:0] | 8'h10};
      if (op == OPI) x = {16'h0, r2[15:0]};
      y = r[3:0] == 4'h4 ? DLB + {21'h0, r2[10:0]} : SRC + r2[15:0];
      kv = r[3:0] == 4'h1 ? r[15:8] : 8'h5A;
      mv = r[3:0] == 4'h2 ? 8'hAA : 8'h00;
      fv = r[3:0] == 4'h3;
      run(op, x, y, {4'h0, r2[31:20]});
    end
    $display("random operations done");
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    chk_res(pass_fail_result, 8'h00);
    pg = '0;
    rst_n <= 1'b1;
    run(OPP, 32'h0, SRC, 16'h0);
    $display("reset recovery done");
    print_verdict();
  end
endmodule

`default_nettype wire

// File: fps_page_state.sv
`default_nettype none

module fps_page_state #(
  parameter int PAGE_W = 12,
  parameter int BLK_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [PAGE_W-1:0] page_idx,
  input wire logic mark_page,
  input wire logic clear_block,
  input wire logic [BLK_W-1:0] block_idx,
  output logic page_written
);

  localparam int PAGES = 1 << PAGE_W;

  logic [PAGES-1:0] written_ff;
  logic [PAGES-1:0] nxt_written;

  // ----------------------------------------------------------------
  // One bit per page remembers that the page holds data.
  // ----------------------------------------------------------------
  always_comb begin
    nxt_written = written_ff;
    for (int i = 0; i < PAGES; i++) begin
      if (clear_block &&
          (i[PAGE_W-1 -: BLK_W] == block_idx)) begin
        nxt_written[i] = 1'b0;
      end
    end
    if (mark_page) begin
      nxt_written[page_idx] = 1'b1;
    end
    page_written = written_ff[page_idx];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      written_ff <= '0;
    end else begin
      written_ff <= nxt_written;
    end
  end

endmodule

`default_nettype wire

// File: fps_pkg.sv
`default_nettype none

package fps_pkg;

  typedef enum logic [2:0] {
    FPS_OP_INIT = 3'h1,
    FPS_OP_PROG = 3'h2,
    FPS_OP_ERASE = 3'h4
  } fps_op_t;

  typedef enum logic [3:0] {
    FPS_ST_IDLE = 4'h1,
    FPS_ST_CHECK = 4'h2,
    FPS_ST_WORK = 4'h4,
    FPS_ST_DONE = 4'h8
  } fps_state_t;

  typedef struct packed {
    fps_op_t op;
    logic [15:0] freq;
    logic [31:0] branch;
    logic [31:0] dest;
    logic [31:0] src;
    logic [31:0] block;
  } fps_req_t;

endpackage

`default_nettype wire

// File: fps_range_check.sv
`default_nettype none

module fps_range_check (
  input wire logic [31:0] addr,
  input wire logic [31:0] base,
  input wire logic [31:0] size,
  output logic hit
);

  logic [31:0] offset;

  // ----------------------------------------------------------------
  // Window test, base inclusive, base plus size exclusive.
  // ----------------------------------------------------------------
  always_comb begin
    offset = addr - base;
    hit = (addr >= base) && (offset < size);
  end

endmodule

`default_nettype wire
